// *** hw/gaoc_top.sv ***
// gauge alert output, hysteresis flags and operating configuration
// Function
// - polarity bit sets alert active level
// - function bit picks low level or pulses
// - low level mode follows low charge flag
// - low flag sets below 150 mAh
// - low flag clears only above 175 mAh
// - final flag sets below 75 mAh
// - final flag clears above 100 mAh if set
// - each pulse mode event gives 1 ms pulse
// - charging pulses on reaching an interval point
// - discharging pulses on falling below interval point
// - state change pulses; zero step disables both
// - pin removal pulses when pin detection enabled
// - presence from pin, else host subcommand
// - sleep only while permit bit set
// - termination loads full charge capacity
// - host temperature if enabled, else sensor
// - reserve compensation bit drives compensation enable
// - bit six reserved, no effect
// - validity bytes: 55 on, 00 updated, ff untouched
// - two tables of fifteen, factory restorable
// - battery state from capacity over divisors
`timescale 1ns/1ps
`default_nettype none
module gaoc_top
   import gaoc_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter logic [15:0] LOW_SET = LOW_SET_MAH,
   parameter logic [15:0] LOW_CLR = LOW_CLR_MAH,
   parameter logic [15:0] FIN_SET = FIN_SET_MAH,
   parameter logic [15:0] FIN_CLR = FIN_CLR_MAH
)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cfg_wr,
   input wire logic [CFG_W-1:0] cfg_wdata,
   output logic [CFG_W-1:0] cfg_rdata,
   input wire logic cap_wr,
   input wire logic [CAP_W-1:0] cap_wdata,
   input wire logic [CAP_W-1:0] full_charge_capacity,
   input wire logic [CAP_W-1:0] design_capacity,
   input wire logic signed [15:0] avg_current,
   input wire logic [6:0] state_of_charge,
   input wire logic [7:0] interval_step_setting,
   input wire logic charge_term,
   input wire logic insertion_detect_pin,
   input wire logic insert_battery_subcommand,
   input wire logic remove_battery_subcommand,
   input wire logic temp_wr,
   input wire logic [15:0] temp_wdata,
   input wire logic [15:0] internal_temp,
   input wire logic sleep_cond,
   input wire logic ra_wr,
   input wire logic [RA_AW-1:0] ra_addr,
   input wire logic [RA_W-1:0] ra_wdata,
   input wire logic factory_restore,
   output logic [RA_W-1:0] ra_rdata,
   output logic alert_output_pin,
   output logic low_charge_warning_flag,
   output logic final_charge_warning_flag,
   output logic [CAP_W-1:0] remaining_capacity,
   output logic battery_present,
   output logic [1:0] battery_state,
   output logic [15:0] temperature,
   output logic sleep_permit,
   output logic reserve_comp_en
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [CFG_W-1:0] cfg;   // operating_configuration
      logic [CAP_W-1:0] rcap;  // remaining capacity
      logic low_f;             // low charge warning
      logic fin_f;             // final charge warning
      logic [6:0] soc_q;       // previous state of charge
      gaoc_state_t st;         // battery activity
      logic pin_q;             // previous insertion pin level
      logic present;           // battery present
      logic [15:0] htemp;      // host written temperature
      logic [15:0] temp;       // temperature in use
      logic slp;               // sleep permitted
      logic pulse;             // pulse in progress
      logic [PCNT_W-1:0] pcnt; // pulse cycles left
      logic [PEND_W-1:0] pend; // queued pulses
      logic alert;             // pin level
   } gaoc_top_t;

   // pin idles high: polarity low and no pulse after reset
   localparam gaoc_top_t TOP_RST = '{
      cfg: CFG_RST, rcap: '0, low_f: 1'b0, fin_f: 1'b0,
      soc_q: '0, st: GAOC_RELAX, pin_q: 1'b1, present: 1'b0,
      htemp: HTEMP_RST, temp: '0, slp: 1'b0, pulse: 1'b0,
      pcnt: '0, pend: '0, alert: 1'b1
   };

   gaoc_top_t s;
   gaoc_top_t next_s;

   // ****************************************
   // battery activity classification
   // ****************************************
   logic [19:0] chg_thr;             // charge current threshold
   logic [19:0] dsg_thr;             // discharge current threshold
   logic [19:0] quit_thr;            // relaxation band
   logic signed [20:0] cur;          // sign extended current
   logic signed [20:0] chg_s;
   logic signed [20:0] dsg_s;
   logic signed [20:0] quit_s;
   gaoc_state_t next_st;             // activity for next cycle

   assign chg_thr = (20'(design_capacity) * 20'd10) / CHG_DIV_X10;
   assign dsg_thr = (20'(design_capacity) * 20'd10) / DSG_DIV_X10;
   assign quit_thr = (20'(design_capacity) * 20'd10) / QUIT_DIV_X10;
   assign cur = 21'(avg_current);
   assign chg_s = $signed({1'b0, chg_thr});
   assign dsg_s = $signed({1'b0, dsg_thr});
   assign quit_s = $signed({1'b0, quit_thr});

   // activity holds inside the dead bands between thresholds
   always_comb
   begin
      if (cur > chg_s)
         next_st = GAOC_CHG;
      else if (cur < -dsg_s)
         next_st = GAOC_DSG;
      else if (cur < quit_s && cur > -quit_s)
         next_st = GAOC_RELAX;
      else
         next_st = s.st;
   end

   // ****************************************
   // pulse events
   // ****************************************
   logic step_on;  // interval and state pulses enabled
   logic pulse_md; // interrupt pulse function selected
   logic soc_ev;   // interval point crossed
   logic state_ev; // activity changed
   logic rem_ev;   // removal seen on the pin
   logic [7:0] lvl_now;
   logic [7:0] lvl_old;

   // number of interval points above a charge level, rounded up;
   // a crossing is a fall of this count while charging or a rise while discharging
   function automatic logic [7:0] gaoc_lvl(input logic [6:0] v,
                                           input logic [7:0] step);
      logic [7:0] gap;
      gap = 8'(SOC_FULL - v);
      if (step == 8'h00)
         return 8'h00;
      return (gap + step - 8'd1) / step;
   endfunction : gaoc_lvl

   assign step_on = interval_step_setting != 8'h00;
   assign pulse_md = !s.cfg[CFG_LOWF_B];
   assign lvl_now = gaoc_lvl(state_of_charge, interval_step_setting);
   assign lvl_old = gaoc_lvl(s.soc_q, interval_step_setting);

   assign soc_ev = pulse_md && step_on &&
      ((s.st == GAOC_CHG && lvl_now < lvl_old) ||
       (s.st == GAOC_DSG && lvl_now > lvl_old));

   // activity change, off with zero step
   assign state_ev = pulse_md && step_on && next_st != s.st;

   // removal is a rising pin edge
   assign rem_ev = pulse_md && s.cfg[CFG_BIE_B] && !s.pin_q &&
      insertion_detect_pin;

   // ****************************************
   // next state
   // ****************************************
   logic [PEND_W:0] pend_sum; // queued plus new events
   logic act;                 // alert asserted before polarity

   always_comb
   begin
      next_s = s;
      pend_sum = (PEND_W+1)'(s.pend) + (PEND_W+1)'(soc_ev) +
         (PEND_W+1)'(state_ev) + (PEND_W+1)'(rem_ev);
      // bit six stored, never read by logic
      if (cfg_wr)
         next_s.cfg = cfg_wdata;

      if (charge_term && s.cfg[CFG_RMF_B])
         next_s.rcap = full_charge_capacity;
      else if (cap_wr)
         next_s.rcap = cap_wdata;

      if (s.rcap < LOW_SET)
         next_s.low_f = 1'b1;
      else if (s.rcap > LOW_CLR)
         next_s.low_f = 1'b0;

      // final flag, clears only if set
      if (s.rcap < FIN_SET)
         next_s.fin_f = 1'b1;
      else if (s.fin_f && s.rcap > FIN_CLR)
         next_s.fin_f = 1'b0;

      next_s.soc_q = state_of_charge;
      next_s.st = next_st;
      next_s.pin_q = insertion_detect_pin;

      // presence by pin edges or subcommand
      if (s.cfg[CFG_BIE_B])
      begin
         // high to low inserts, low to high removes
         if (s.pin_q && !insertion_detect_pin)
            next_s.present = 1'b1;
         else if (!s.pin_q && insertion_detect_pin)
            next_s.present = 1'b0;
      end
      else if (insert_battery_subcommand)
         next_s.present = 1'b1;
      else if (remove_battery_subcommand)
         next_s.present = 1'b0;

      if (temp_wr && s.cfg[CFG_TEMP_B])
         next_s.htemp = temp_wdata;
      if (s.cfg[CFG_TEMP_B])
         next_s.temp = s.htemp;
      else
         next_s.temp = internal_temp;

      next_s.slp = s.cfg[CFG_SLP_B] && sleep_cond;

      // pulse engine runs only in pulse mode
      if (!pulse_md)
      begin
         // queue is dropped when the level function takes over
         next_s.pulse = 1'b0;
         next_s.pcnt = '0;
         next_s.pend = '0;
      end
      else if (s.pulse)
      begin
         if (s.pcnt == '0)
            next_s.pulse = 1'b0;
         else
            next_s.pcnt = s.pcnt - PCNT_W'(1);
         if (pend_sum > (PEND_W+1)'({PEND_W{1'b1}}))
            next_s.pend = '1;
         else
            next_s.pend = PEND_W'(pend_sum);
      end
      else if (pend_sum != '0)
      begin
         next_s.pulse = 1'b1;
         next_s.pcnt = PCNT_W'(PULSE_CYCLES - 1);
         if (pend_sum > (PEND_W+1)'({PEND_W{1'b1}}))
            next_s.pend = '1;
         else
            next_s.pend = PEND_W'(pend_sum - (PEND_W+1)'(1));
      end

      if (next_s.cfg[CFG_LOWF_B])
         act = next_s.low_f;
      else
         act = next_s.pulse;
      next_s.alert = next_s.cfg[CFG_POL_B] ? act : !act;
   end

   // ****************************************
   // registers
   // ****************************************
   // one register bank for the whole block except the resistance tables, which keep their own in gaoc_ra_mem
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         s <= TOP_RST;
      else
         s <= next_s;
   end

   // ****************************************
   // resistance tables
   // ****************************************
   // table store with restore
   gaoc_ra_mem u_ra_mem (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .wr(ra_wr),
      .addr(ra_addr),
      .wdata(ra_wdata),
      .restore(factory_restore),
      .rdata(ra_rdata)
   );

   // outputs straight from flops
   assign cfg_rdata = s.cfg;
   assign alert_output_pin = s.alert;
   assign low_charge_warning_flag = s.low_f;
   assign final_charge_warning_flag = s.fin_f;
   assign remaining_capacity = s.rcap;
   assign battery_present = s.present;
   assign battery_state = s.st;
   assign temperature = s.temp;
   assign sleep_permit = s.slp;
   assign reserve_comp_en = s.cfg[CFG_RESC_B];

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_low_level_track: assert property (
      s.cfg[CFG_LOWF_B] |->
         alert_output_pin == (s.cfg[CFG_POL_B] ~^ s.low_f))
      else $error("alert does not follow low flag");

   chk_pulse_polarity: assert property (
      !s.cfg[CFG_LOWF_B] |->
         alert_output_pin == (s.cfg[CFG_POL_B] ~^ s.pulse))
      else $error("alert polarity wrong in pulse mode");

   chk_low_set: assert property (
      s.rcap < LOW_SET |=> s.low_f)
      else $error("low flag not set");

   chk_low_hold: assert property (
      s.low_f && s.rcap <= LOW_CLR |=> s.low_f)
      else $error("low flag cleared inside hysteresis");

   chk_final_set: assert property (
      s.rcap < FIN_SET |=> s.fin_f)
      else $error("final flag not set");

   chk_final_clear: assert property (
      s.fin_f && s.rcap > FIN_CLR && s.rcap >= FIN_SET |=> !s.fin_f)
      else $error("final flag not cleared");

   chk_pulse_start: assert property (
      $rose(s.pulse) |-> s.pcnt == PCNT_W'(PULSE_CYCLES - 1))
      else $error("pulse started with wrong length");

   chk_pulse_end: assert property (
      s.pulse && s.pcnt == '0 && pulse_md |=> !s.pulse)
      else $error("pulse did not end");

   chk_step_zero: assert property (
      !step_on && !rem_ev && !s.pulse && s.pend == '0 |=> !s.pulse)
      else $error("pulse started with zero step");

   chk_event_queued: assert property (
      (soc_ev || state_ev || rem_ev) && pulse_md
         ##1 pulse_md |-> s.pulse || s.pend != '0)
      else $error("event lost");

   chk_term_load: assert property (
      charge_term && s.cfg[CFG_RMF_B] |=>
         s.rcap == $past(full_charge_capacity))
      else $error("capacity not loaded at termination");

   chk_sleep_gate: assert property (
      s.slp |-> $past(s.cfg[CFG_SLP_B]))
      else $error("sleep permitted with bit clear");

endmodule : gaoc_top
`default_nettype wire

// *** hw/gaoc_pkg.sv ***
// constants and types for the gauge alert and configuration block
package gaoc_pkg;

   // configuration byte layout
   localparam int CFG_W = 8;
   localparam int CFG_TEMP_B = 0;
   localparam int CFG_POL_B = 1;
   localparam int CFG_BIE_B = 2;
   localparam int CFG_RMF_B = 3;
   localparam int CFG_SLP_B = 4;
   localparam int CFG_LOWF_B = 5;
   localparam int CFG_RSVD_B = 6;
   localparam int CFG_RESC_B = 7;
   localparam logic [7:0] CFG_RST = 8'h19;

   // capacity thresholds in mAh
   localparam int CAP_W = 16;
   localparam logic [15:0] LOW_SET_MAH = 16'h0096;
   localparam logic [15:0] LOW_CLR_MAH = 16'h00af;
   localparam logic [15:0] FIN_SET_MAH = 16'h004b;
   localparam logic [15:0] FIN_CLR_MAH = 16'h0064;

   // state of charge scale and current divisors times ten
   localparam logic [6:0] SOC_FULL = 7'h64;
   localparam logic [19:0] CHG_DIV_X10 = 20'h00085;
   localparam logic [19:0] DSG_DIV_X10 = 20'h000a7;
   localparam logic [19:0] QUIT_DIV_X10 = 20'h000fa;

   // alert pulse timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_WIDTH_NS = 1000000;
   localparam int PULSE_CYC = PULSE_WIDTH_NS / CLK_PERIOD_NS;
   localparam int PCNT_W = 17;
   localparam int PEND_W = 4;

   // host temperature default, 25 C in tenths of kelvin
   localparam logic [15:0] HTEMP_RST = 16'h0ba6;

   // resistance tables
   localparam int RA_TABLES = 2;
   localparam int RA_ENTRIES = 15;
   localparam int RA_W = 16;
   localparam int RA_AW = 5;
   localparam logic [15:0] RA_DEF = 16'h0066;
   localparam logic [3:0] RA_FLAG_IDX = 4'hf;
   localparam logic [7:0] RA_ON = 8'h55;
   localparam logic [7:0] RA_UPDATED = 8'h00;
   localparam logic [7:0] RA_UNTOUCHED = 8'hff;
   localparam logic [15:0] RA_VF_RST = {RA_UNTOUCHED, RA_ON};

   // battery activity
   typedef enum logic [1:0] {GAOC_RELAX, GAOC_CHG, GAOC_DSG} gaoc_state_t;

endpackage : gaoc_pkg

// *** hw/gaoc_ra_mem.sv ***
// resistance table store with validity bytes and registered read
`timescale 1ns/1ps
`default_nettype none
module gaoc_ra_mem
   import gaoc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wr,
   input wire logic [RA_AW-1:0] addr,
   input wire logic [RA_W-1:0] wdata,
   input wire logic restore,
   output logic [RA_W-1:0] rdata
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [RA_TABLES*RA_ENTRIES-1:0][RA_W-1:0] ra; // table values
      logic [RA_TABLES-1:0][7:0] vf;                // validity bytes
      logic [RA_W-1:0] rd;                          // read register
   } gaoc_mem_t;

   localparam gaoc_mem_t MEM_RST = '{
      ra: {RA_TABLES*RA_ENTRIES{RA_DEF}},
      vf: RA_VF_RST,
      rd: '0
   };

   gaoc_mem_t s;
   gaoc_mem_t next_s;
   logic [RA_AW-1:0] ent; // flat entry index
   logic is_flag;         // address points at a validity byte

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_s = s;
      is_flag = addr[3:0] == RA_FLAG_IDX;
      // second table follows the first in the flat array
      if (addr[RA_AW-1])
         ent = RA_AW'(addr[3:0]) + RA_AW'(RA_ENTRIES);
      else
         ent = RA_AW'(addr[3:0]);
      if (restore)
      begin
         next_s.ra = {RA_TABLES*RA_ENTRIES{RA_DEF}};
         next_s.vf = RA_VF_RST;
      end
      else if (wr && is_flag)
         next_s.vf[addr[RA_AW-1]] = wdata[7:0];
      else if (wr)
         next_s.ra[ent] = wdata;
      // read reflects storage before this cycle's write
      if (is_flag)
         next_s.rd = {8'h00, s.vf[addr[RA_AW-1]]};
      else
         next_s.rd = s.ra[ent];
   end

   // registers, reset loads the factory image
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         s <= MEM_RST;
      else
         s <= next_s;
   end

   assign rdata = s.rd;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_restore_flags: assert property (
      restore |=> s.vf[0] == RA_ON && s.vf[1] == RA_UNTOUCHED)
      else $error("validity bytes not restored");

   chk_restore_values: assert property (
      restore |=> s.ra[0] == RA_DEF && s.ra[29] == RA_DEF)
      else $error("table values not restored");

endmodule : gaoc_ra_mem
`default_nettype wire

// *** bench/gaoc_host_model.sv ***
// host side model: watches alert pulses and drives the insertion pin
`timescale 1ns/1ps
`default_nettype none
module gaoc_host_model
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic alert_output_pin,
   input wire logic active_high,
   output logic insertion_detect_pin,
   output logic [7:0] pulse_cnt,
   output logic [7:0] pulse_width
);
   // cycles the present pulse has been active so far
   logic [7:0] run;
   // weak pull-up keeps the pin high until the host pulls it down
   initial insertion_detect_pin = 1'b1;
   // count pulses at their start, keep the width of the last one
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pulse_cnt <= 8'h00;
         pulse_width <= 8'h00;
         run <= 8'h00;
      end
      else if (alert_output_pin === active_high)
      begin
         if (run == 8'h00)
            pulse_cnt <= pulse_cnt + 8'h01;
         run <= run + 8'h01;
      end
      else
      begin
         // width is known only once the pulse has ended
         if (run != 8'h00)
            pulse_width <= run;
         run <= 8'h00;
      end
   end
   task automatic drive_pin(input logic level);
      @(posedge ref_clk);
      #1;
      insertion_detect_pin = level;
   endtask : drive_pin
endmodule : gaoc_host_model
`default_nettype wire

// *** bench/gaoc_top_bench.sv ***
// self-checking bench for the gauge alert and configuration block
`timescale 1ns/1ps
`default_nettype none
module gaoc_top_bench
   import gaoc_pkg::*;
;
   // short pulse keeps the run brief
   localparam int PW = 8;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic cfg_wr = 1'b0, cap_wr = 1'b0, charge_term = 1'b0, temp_wr = 1'b0;
   logic ins_cmd = 1'b0, rem_cmd = 1'b0, ra_wr = 1'b0, factory_restore = 1'b0;
   logic sleep_cond = 1'b1;
   logic [7:0] cfg_wdata = 8'h00, step = 8'h00, cfg_rdata, pcnt, pwid, base;
   logic [15:0] cap_wdata = 16'h0000, fcc = 16'h0200, dc = 16'h0532;
   logic [15:0] temp_wdata = 16'h0000, int_temp = 16'h0456, temperature;
   logic [15:0] ra_wdata = 16'h0000, ra_rdata, rcap;
   logic signed [15:0] cur = 16'sh0000;
   logic [6:0] soc = 7'h37;
   logic [4:0] ra_addr = 5'h00;
   logic alert, low_f, fin_f, present, sleep_permit, rcomp, pin;
   logic [1:0] bstate;
   int n_errors = 0;
   int n_checks = 0;
   // capacity steps with expected low and final flags, bit i per step
   logic [15:0] hcap [10] = '{16'h00a0, 16'h00b0, 16'h0096, 16'h0095,
      16'h0050, 16'h004a, 16'h0064, 16'h0065, 16'h00af, 16'h00b0};
   logic [9:0] hlow = 10'b0111111001;
   logic [9:0] hfin = 10'b0001100000;
   // currents around the thresholds of a 1330 mAh design
   logic signed [15:0] ccur [6] = '{16'sd100, 16'sd101, 16'sd52,
      -16'sd79, -16'sd80, 16'sd0};
   logic [1:0] cst [6] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0};

   gaoc_top #(.PULSE_CYCLES(PW)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cap_wr(cap_wr), .cap_wdata(cap_wdata), .full_charge_capacity(fcc),
      .design_capacity(dc), .avg_current(cur), .state_of_charge(soc),
      .interval_step_setting(step), .charge_term(charge_term),
      .insertion_detect_pin(pin), .insert_battery_subcommand(ins_cmd),
      .remove_battery_subcommand(rem_cmd), .temp_wr(temp_wr),
      .temp_wdata(temp_wdata), .internal_temp(int_temp),
      .sleep_cond(sleep_cond), .ra_wr(ra_wr), .ra_addr(ra_addr),
      .ra_wdata(ra_wdata), .factory_restore(factory_restore),
      .ra_rdata(ra_rdata), .alert_output_pin(alert),
      .low_charge_warning_flag(low_f), .final_charge_warning_flag(fin_f),
      .remaining_capacity(rcap), .battery_present(present),
      .battery_state(bstate), .temperature(temperature),
      .sleep_permit(sleep_permit), .reserve_comp_en(rcomp));

   gaoc_host_model host (.ref_clk(ref_clk), .resetn(resetn),
      .alert_output_pin(alert), .active_high(cfg_rdata[CFG_POL_B]),
      .insertion_detect_pin(pin), .pulse_cnt(pcnt), .pulse_width(pwid));

   // 100 MHz reference
   always #5 ref_clk = ~ref_clk;

   // ****************************************
   // access tasks
   // ****************************************
   // inputs always move one ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one cycle strobe, then room for the registered answer
   task automatic strobe(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(3);
   endtask : strobe
   task automatic cfg_write(input logic [7:0] v);
      cfg_wdata = v;
      strobe(cfg_wr);
   endtask : cfg_write
   task automatic cap_write(input logic [15:0] v);
      cap_wdata = v;
      strobe(cap_wr);
   endtask : cap_write
   // read answers one cycle after the address
   task automatic ra_read(input logic [4:0] a, input logic [15:0] exp);
      ra_addr = a;
      tick(2);
      chk("table word", exp, ra_rdata);
   endtask : ra_read
   // bounded wait for n more pulses, then make sure no extra one follows
   task automatic expect_pulses(input logic [7:0] n);
      int i;
      for (i = 0; i < 60 && pcnt !== base + n; i++)
         tick(1);
      if (i == 60)
      begin
         n_errors++;
         $display("BAD pulse wait expected %h seen %h", base + n, pcnt);
         complete_run();
      end
      tick(2 * PW + 4);
      chk("pulse count", base + n, pcnt);
      base = pcnt;
   endtask : expect_pulses
   task automatic end_test(input string name);
      $display("test %s done, errors so far %0d", name, n_errors);
   endtask : end_test
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (12) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      tick(3);
      chk("config reset", CFG_RST, cfg_rdata);
      chk("low flag", 16'h0001, low_f);
      chk("final flag", 16'h0001, fin_f);
      chk("host temp default", HTEMP_RST, temperature);
      end_test("reset");
      // bit six is only stored, never acted on
      cfg_write(8'hc6);
      chk("config", 16'h00c6, cfg_rdata);
      chk("reserve comp", 16'h0001, rcomp);
      chk("sleep permit", 16'h0000, sleep_permit);
      cfg_write(8'h11);
      chk("sleep permit", 16'h0001, sleep_permit);
      chk("reserve comp", 16'h0000, rcomp);
      // permit bit alone must not allow sleep without the condition
      sleep_cond = 1'b0;
      tick(3);
      chk("sleep blocked", 16'h0000, sleep_permit);
      sleep_cond = 1'b1;
      temp_wdata = 16'h0123;
      strobe(temp_wr);
      chk("host temp", 16'h0123, temperature);
      cfg_write(8'h10);
      temp_wdata = 16'h0789;
      strobe(temp_wr);
      chk("sensor temp", 16'h0456, temperature);
      end_test("config");
      // level function, active high: pin follows the low flag
      cfg_write(8'h22);
      for (int i = 0; i < 10; i++)
      begin
         cap_write(hcap[i]);
         chk("low flag", {15'h0000, hlow[i]}, low_f);
         chk("final flag", {15'h0000, hfin[i]}, fin_f);
         chk("alert level", {15'h0000, hlow[i]}, alert);
      end
      cfg_write(8'h20);
      chk("alert low active", 16'h0001, alert);
      cap_write(16'h0095);
      chk("alert low active", 16'h0000, alert);
      end_test("hysteresis");
      cfg_write(8'h28);
      strobe(charge_term);
      chk("capacity", fcc, rcap);
      cfg_write(8'h20);
      cap_write(16'h000a);
      strobe(charge_term);
      chk("capacity", 16'h000a, rcap);
      end_test("termination");
      for (int i = 0; i < 6; i++)
      begin
         cur = ccur[i];
         tick(3);
         chk("battery state", {14'h0000, cst[i]}, bstate);
      end
      end_test("classification");
      // pulse function, active high, ten percent step
      step = 8'h0a;
      cfg_write(8'h02);
      base = pcnt;
      cur = 16'sd200;
      expect_pulses(8'h01);
      soc = 7'h3c;
      expect_pulses(8'h01);
      chk("pulse width", 16'(PW), pwid);
      soc = 7'h3d;
      expect_pulses(8'h00);
      cur = -16'sd200;
      expect_pulses(8'h01);
      soc = 7'h3b;
      expect_pulses(8'h01);
      soc = 7'h27;
      tick(1);
      soc = 7'h1d;
      expect_pulses(8'h02);
      chk("pulse width", 16'(PW), pwid);
      step = 8'h00;
      cur = 16'sd0;
      expect_pulses(8'h00);
      soc = 7'h13;
      expect_pulses(8'h00);
      end_test("pulses");
      cfg_write(8'h06);
      base = pcnt;
      host.drive_pin(1'b0);
      tick(3);
      chk("present", 16'h0001, present);
      expect_pulses(8'h00);
      host.drive_pin(1'b1);
      tick(3);
      chk("present", 16'h0000, present);
      expect_pulses(8'h01);
      cfg_write(8'h02);
      strobe(ins_cmd);
      chk("present", 16'h0001, present);
      strobe(rem_cmd);
      chk("present", 16'h0000, present);
      end_test("presence");
      ra_read(5'h00, RA_DEF);
      ra_read(5'h0e, RA_DEF);
      ra_read(5'h0f, {8'h00, RA_ON});
      ra_read(5'h1f, {8'h00, RA_UNTOUCHED});
      ra_addr = 5'h13;
      ra_wdata = 16'h1234;
      strobe(ra_wr);
      ra_read(5'h13, 16'h1234);
      // mark the first table as updated but not in use
      ra_addr = 5'h0f;
      ra_wdata = 16'h0000;
      strobe(ra_wr);
      ra_read(5'h0f, {8'h00, RA_UPDATED});
      strobe(factory_restore);
      ra_read(5'h13, RA_DEF);
      ra_read(5'h0f, {8'h00, RA_ON});
      end_test("tables");
      complete_run();
   end
endmodule : gaoc_top_bench
`default_nettype wire
